/* src/dmc_core.v */
// Notes on behaviour
// - each channel holds one source/destination pair
// - every item is one read then one write
// - source and destination widths chosen independently
// - four channels, sixteen hardware request lines
// - one input selects round robin or fixed
// - fixed priority: highest channel number wins
// - peripherals sit on fixed request line numbers
// - single interrupt line, controller source twenty
// - memory endpoints always ready, no handshake
// - handshake per side, reprogrammable per channel
// - requests from hardware lines or software
// - single transaction is one non-burst access
// - chunk of at most sixteen items, issued as two-beat incrementing bursts only when both sides increment, else singles
// - memory splits to bursts, peripherals to transactions
// - the controller sets each buffer's amount
// - last buffer done disables channel, signals
// - chaining fetches descriptor at every buffer start
// - source and destination pick chaining independently
// - contiguous side continues from previous end address
// - increment, decrement or fixed per side
// - channel lock holds arbitration for its span
// - bus lock drives hmastlock, channel lock covers it
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.vh"

module dmc_core (
  input wire clock,
  input wire rst_n,
  input wire arbitration_policy_select,
  input wire [3:0] ch_enable,
  input wire [127:0] ch_src_addr,
  input wire [127:0] ch_dst_addr,
  input wire [127:0] ch_desc_ptr,
  input wire [47:0] ch_buf_size,
  input wire [7:0] ch_src_size,
  input wire [7:0] ch_dst_size,
  input wire [7:0] ch_src_mode,
  input wire [7:0] ch_dst_mode,
  input wire [3:0] ch_src_mem,
  input wire [3:0] ch_dst_mem,
  input wire [3:0] ch_src_hw,
  input wire [3:0] ch_dst_hw,
  input wire [15:0] ch_src_line,
  input wire [15:0] ch_dst_line,
  input wire [3:0] ch_src_chain,
  input wire [3:0] ch_dst_chain,
  input wire [15:0] ch_chunk,
  input wire [7:0] ch_chan_lock,
  input wire [7:0] ch_bus_lock,
  input wire [15:0] hw_single_req,
  input wire [15:0] hw_chunk_req,
  input wire [7:0] sw_single_set,
  input wire [7:0] sw_chunk_set,
  output wire [7:0] sw_single_pend,
  output wire [7:0] sw_chunk_pend,
  output reg [15:0] hw_ack,
  output wire [3:0] ch_active,
  output reg [3:0] ch_done,
  output reg dma_irq,
  output wire [31:0] haddr,
  output wire [1:0] htrans,
  output wire hwrite,
  output wire [2:0] hsize,
  output wire [2:0] hburst,
  output wire [3:0] hprot,
  output wire hmastlock,
  output reg [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hready
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FETCH = 4'h2;
  localparam [3:0] ST_RD = 4'h4;
  localparam [3:0] ST_WR = 4'h8;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next address after one item of the given width
  function [31:0] nxa;
    input [31:0] a;
    input [1:0] mode;
    input [1:0] sz;
    reg [31:0] step;
    begin
      step = 32'h0000_0001 << sz;
      case (mode)
        `DMC_AM_INC: nxa = a + step;
        `DMC_AM_DEC: nxa = a - step;
        default: nxa = a;
      endcase
    end
  endfunction

  // Take one item off its byte lanes, zero extended
  function [31:0] ext;
    input [31:0] d;
    input [1:0] lo;
    input [1:0] sz;
    reg [31:0] sh;
    begin
      sh = d >> {lo, 3'b000};
      case (sz)
        `DMC_SZ_BYTE: ext = {24'h00_0000, sh[7:0]};
        `DMC_SZ_HALF: ext = {16'h0000, sh[15:0]};
        default: ext = d;
      endcase
    end
  endfunction

  // Copy an item onto every lane so any address offset sees it
  function [31:0] rep;
    input [31:0] d;
    input [1:0] sz;
    begin
      case (sz)
        `DMC_SZ_BYTE: rep = {4{d[7:0]}};
        `DMC_SZ_HALF: rep = {2{d[15:0]}};
        default: rep = d;
      endcase
    end
  endfunction

  // Beats in the next read/write piece; bursts only when both
  // sides increment, since a fixed or falling address cannot burst
  function [2:0] pcs;
    input [4:0] tl;
    input bi;
    begin
      pcs = (bi && tl > 5'h01) ? 3'h2 : 3'h1;
    end
  endfunction

  // Widest span of two lock scopes (lower nonzero code is wider)
  function [1:0] wide;
    input [1:0] a;
    input [1:0] b;
    begin
      if (a == `DMC_LK_NONE)
        wide = b;
      else if (b == `DMC_LK_NONE || a < b)
        wide = a;
      else
        wide = b;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [3:0] st;
  reg [1:0] gch;
  reg [31:0] sa [0:3];
  reg [31:0] da [0:3];
  reg [31:0] dp [0:3];
  reg [11:0] rem [0:3];
  reg [3:0] en;
  reg [3:0] fpend;
  reg [4:0] tleft;
  reg [2:0] pn;
  reg [2:0] ac;
  reg [2:0] dc;
  reg dph;
  reg [1:0] dlo;
  reg held;
  reg bheld;
  reg [1:0] hscope;
  reg [1:0] bscope;
  reg [31:0] fd_s;
  reg [31:0] fd_d;
  reg [31:0] fd_p;
  reg [31:0] fb [0:1];
  reg wp;
  reg rp;
  reg [1:0] fcnt;
  wire [3:0] cand;
  wire [3:0] chk;

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  wire s_fetch = (st == ST_FETCH);
  wire s_rd = (st == ST_RD);
  wire s_wr = (st == ST_WR);
  wire [1:0] ssz = ch_src_size[{gch, 1'b0} +: 2];
  wire [1:0] dsz = ch_dst_size[{gch, 1'b0} +: 2];
  wire [1:0] smd = ch_src_mode[{gch, 1'b0} +: 2];
  wire [1:0] dmd = ch_dst_mode[{gch, 1'b0} +: 2];
  wire bi_g = (smd == `DMC_AM_INC) && (dmd == `DMC_AM_INC);
  // Buffer full on the fill side stalls read issue; drain side feeds writes
  wire f_rdy = (fcnt != 2'h2);
  wire f_vld = (fcnt != 2'h0);
  wire issue = (ac < pn) & ((s_fetch | s_rd) & f_rdy | s_wr & f_vld);
  wire acc = issue & hready;
  wire dfin = dph & hready;
  wire last = dfin & (dc == pn - 3'h1);
  wire [11:0] pn12 = {9'h000, pn};
  wire buf_end = s_wr & last & (rem[gch] == pn12);
  wire txn_end = s_wr & last & ((tleft == {2'h0, pn}) | (rem[gch] == pn12));
  wire xfer_end = buf_end & (dp[gch] == `DMC_NULL_PTR);
  wire [3:0] gsel = 4'h1 << gch;

  // Each lock ends with the event that closes its chosen span
  function ends;
    input [1:0] s;
    begin
      case (s)
        `DMC_LK_XFER: ends = xfer_end;
        `DMC_LK_BUF: ends = buf_end;
        `DMC_LK_TXN: ends = txn_end;
        default: ends = 1'b0;
      endcase
    end
  endfunction

  // Read, then write of the same item through the buffer
  assign htrans = !issue ? `DMC_HT_IDLE :
                  (ac == 3'h0) ? `DMC_HT_NONSEQ : `DMC_HT_SEQ;
  assign haddr = s_fetch ? dp[gch] + {27'h000_0000, ac, 2'b00} :
                 s_wr ? da[gch] : sa[gch];
  assign hwrite = s_wr;
  assign hsize = s_fetch ? {1'b0, `DMC_SZ_WORD} :
                 s_wr ? {1'b0, dsz} : {1'b0, ssz};
  // One beat is a plain single access, more is an incrementing burst
  assign hburst = (pn == 3'h1) ? `DMC_HB_SINGLE : `DMC_HB_INCR;
  assign hprot = 4'h1;
  assign hmastlock = bheld;
  assign ch_active = en;

  // ----------------------------------------------------------------
  // Per-channel handshake and readiness
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_ch
      wire [3:0] sl = ch_src_line[4*c+3:4*c];
      wire [3:0] dl = ch_dst_line[4*c+3:4*c];
      wire clr = txn_end & gsel[c];
      reg ss;
      reg sc;
      reg ds;
      reg dk;
      // Software latches; a new request wins over the completion clear
      always @(posedge clock) begin
        if (!rst_n) begin
          ss <= 1'b0;
          sc <= 1'b0;
          ds <= 1'b0;
          dk <= 1'b0;
        end else begin
          ss <= sw_single_set[2*c] | (ss & ~clr);
          sc <= sw_chunk_set[2*c] | (sc & ~clr);
          ds <= sw_single_set[2*c+1] | (ds & ~clr);
          dk <= sw_chunk_set[2*c+1] | (dk & ~clr);
        end
      end
      // Handshake source per side, reselected live by the hw flags
      wire sq = ch_src_hw[c] ? (hw_single_req[sl] | hw_chunk_req[sl]) : (ss | sc);
      wire dq = ch_dst_hw[c] ? (hw_single_req[dl] | hw_chunk_req[dl]) : (ds | dk);
      wire sk = ch_src_hw[c] ? hw_chunk_req[sl] : sc;
      wire dkk = ch_dst_hw[c] ? hw_chunk_req[dl] : dk;
      // Memory needs no request and is never waited on
      wire srdy = ch_src_mem[c] | sq;
      wire drdy = ch_dst_mem[c] | dq;
      assign chk[c] = (~ch_src_mem[c] & sk) | (~ch_dst_mem[c] & dkk);
      assign cand[c] = en[c] & (fpend[c] | (srdy & drdy));
      assign sw_single_pend[2*c] = ss;
      assign sw_single_pend[2*c+1] = ds;
      assign sw_chunk_pend[2*c] = sc;
      assign sw_chunk_pend[2*c+1] = dk;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration and transaction sizing
  // ----------------------------------------------------------------
  reg [1:0] pick;
  reg found;
  reg [1:0] idx;
  reg [4:0] base;
  reg [4:0] pk_tl;
  reg pk_bi;
  reg [1:0] pk_lk;
  integer i;
  integer j;
  // A held channel keeps the master; otherwise fixed or rotating choice
  always @* begin
    pick = gch;
    found = 1'b0;
    idx = 2'h0;
    if (held) begin
      found = cand[gch];
    end else if (arbitration_policy_select) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (cand[i]) begin
          pick = i[1:0];
          found = 1'b1;
        end
      end
    end else begin
      for (i = 4; i > 0; i = i - 1) begin
        idx = gch + i[1:0];
        if (cand[idx]) begin
          pick = idx;
          found = 1'b1;
        end
      end
    end
    // Memory pairs run straight bursts, peripherals a single or chunk
    if (ch_src_mem[pick] & ch_dst_mem[pick])
      base = `DMC_MAX_BEATS;
    else if (chk[pick])
      base = {1'b0, ch_chunk[{pick, 2'b00} +: 4]} + 5'h01;
    else
      base = 5'h01;
    // The programmed buffer size bounds every transaction
    pk_tl = (rem[pick] < {7'h00, base}) ? rem[pick][4:0] : base;
    pk_bi = (ch_src_mode[{pick, 1'b0} +: 2] == `DMC_AM_INC) &&
            (ch_dst_mode[{pick, 1'b0} +: 2] == `DMC_AM_INC);
    pk_lk = wide(ch_chan_lock[{pick, 1'b0} +: 2], ch_bus_lock[{pick, 1'b0} +: 2]);
  end

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  // Arrays are per channel, so a channel is bound to one pair at a time
  always @(posedge clock) begin
    if (!rst_n) begin
      st <= ST_IDLE;
      gch <= 2'h0;
      en <= 4'h0;
      fpend <= 4'h0;
      pn <= 3'h1;
      ac <= 3'h0;
      dc <= 3'h0;
      dph <= 1'b0;
      held <= 1'b0;
      bheld <= 1'b0;
      wp <= 1'b0;
      rp <= 1'b0;
      fcnt <= 2'h0;
      hw_ack <= 16'h0000;
      ch_done <= 4'h0;
      dma_irq <= 1'b0;
      for (j = 0; j < 4; j = j + 1) begin
        sa[j] <= 32'h0000_0000;  // Keeps haddr zero when idle after reset, until the channel is loaded
      end
    end else begin
      hw_ack <= 16'h0000;
      ch_done <= 4'h0;
      dma_irq <= 1'b0;
      // Enable loads an idle channel; a non-null pointer fetches first
      for (j = 0; j < 4; j = j + 1) begin
        if (ch_enable[j] & ~en[j]) begin
          en[j] <= 1'b1;
          sa[j] <= ch_src_addr[32*j +: 32];
          da[j] <= ch_dst_addr[32*j +: 32];
          dp[j] <= ch_desc_ptr[32*j +: 32];
          rem[j] <= ch_buf_size[12*j +: 12];
          fpend[j] <= (ch_desc_ptr[32*j +: 32] != `DMC_NULL_PTR);
        end
      end
      // Address phase taken
      if (acc) begin
        ac <= ac + 3'h1;
        dlo <= haddr[1:0];
        if (s_rd)
          sa[gch] <= nxa(sa[gch], smd, ssz);
        if (s_wr) begin
          da[gch] <= nxa(da[gch], dmd, dsz);
          hwdata <= rep(fb[rp], dsz);
          rp <= ~rp;
        end
      end
      // Data phase ends on hready; data phase register holds otherwise
      if (acc)
        dph <= 1'b1;
      else if (hready)
        dph <= 1'b0;
      if (dfin) begin
        dc <= dc + 3'h1;
        if (s_rd) begin
          fb[wp] <= ext(hrdata, dlo, ssz);
          wp <= ~wp;
        end
        if (s_fetch) begin
          case (dc)
            3'h0: fd_s <= hrdata;
            3'h1: fd_d <= hrdata;
            3'h2: fd_p <= hrdata;
            default: ;
          endcase
        end
      end
      fcnt <= fcnt + {1'b0, s_rd & dfin} - {1'b0, s_wr & acc};
      case (st)
        ST_IDLE: begin
          if (held & ~en[gch])
            held <= 1'b0;
          if (found) begin
            gch <= pick;
            ac <= 3'h0;
            dc <= 3'h0;
            if (!held) begin
              // Channel lock spans at least as far as bus lock
              held <= (pk_lk != `DMC_LK_NONE);
              hscope <= pk_lk;
              bheld <= (ch_bus_lock[{pick, 1'b0} +: 2] != `DMC_LK_NONE);
              bscope <= ch_bus_lock[{pick, 1'b0} +: 2];
            end
            if (fpend[pick]) begin
              st <= ST_FETCH;
              pn <= `DMC_DESC_WORDS;
            end else begin
              tleft <= pk_tl;
              pn <= pcs(pk_tl, pk_bi);
              st <= ST_RD;
            end
          end
        end
        ST_FETCH: begin
          if (last) begin
            // Each side takes the fetched address or keeps counting on
            if (ch_src_chain[gch])
              sa[gch] <= fd_s;
            if (ch_dst_chain[gch])
              da[gch] <= fd_d;
            dp[gch] <= fd_p;
            rem[gch] <= hrdata[`DMC_BTS_MSB:0];
            fpend[gch] <= 1'b0;
            st <= ST_IDLE;
          end
        end
        ST_RD: begin
          if (last) begin
            ac <= 3'h0;
            dc <= 3'h0;
            st <= ST_WR;
          end
        end
        ST_WR: begin
          if (last) begin
            ac <= 3'h0;
            dc <= 3'h0;
            tleft <= tleft - {2'h0, pn};
            rem[gch] <= rem[gch] - pn12;
            if (held & ends(hscope))
              held <= 1'b0;
            if (bheld & ends(bscope))
              bheld <= 1'b0;
            if (buf_end & ~xfer_end)
              fpend[gch] <= 1'b1;
            if (xfer_end) begin
              en[gch] <= 1'b0;
              ch_done[gch] <= 1'b1;
              dma_irq <= 1'b1;
            end
            if (txn_end) begin
              // Acknowledge hardware-handshaked sides on their lines
              if (ch_src_hw[gch] & ~ch_src_mem[gch])
                hw_ack[ch_src_line[{gch, 2'b00} +: 4]] <= 1'b1;
              if (ch_dst_hw[gch] & ~ch_dst_mem[gch])
                hw_ack[ch_dst_line[{gch, 2'b00} +: 4]] <= 1'b1;
              st <= ST_IDLE;
            end else begin
              pn <= pcs(tleft - {2'h0, pn}, bi_g);
              st <= ST_RD;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* src/dmc_regs.vh */
`ifndef DMC_REGS_VH
`define DMC_REGS_VH

// ----------------------------------------------------------------
// Channel and request line counts
// ----------------------------------------------------------------
`define DMC_NCH 4
`define DMC_NLINE 16
// Source number of the single interrupt line at the interrupt controller
`define DMC_IRQ_SOURCE 8'h14

// ----------------------------------------------------------------
// Hardware request line numbers of the attached peripherals
// ----------------------------------------------------------------
`define DMC_LINE_CARD_IF 4'h0
`define DMC_LINE_SPI_TX 4'h1
`define DMC_LINE_SPI_RX 4'h2
`define DMC_LINE_SER1_TX 4'h3
`define DMC_LINE_SER1_RX 4'h4
`define DMC_LINE_SER2_TX 4'h5
`define DMC_LINE_SER2_RX 4'h6
`define DMC_LINE_CIPHER_TX 4'hB
`define DMC_LINE_CIPHER_RX 4'hC
`define DMC_LINE_PWM_TX 4'hD

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define DMC_SZ_BYTE 2'h0
`define DMC_SZ_HALF 2'h1
`define DMC_SZ_WORD 2'h2
`define DMC_AM_INC 2'h0
`define DMC_AM_DEC 2'h1
`define DMC_AM_FIX 2'h2
`define DMC_LK_NONE 2'h0
`define DMC_LK_XFER 2'h1
`define DMC_LK_BUF 2'h2
`define DMC_LK_TXN 2'h3
`define DMC_HT_IDLE 2'h0
`define DMC_HT_NONSEQ 2'h2
`define DMC_HT_SEQ 2'h3
`define DMC_HB_SINGLE 3'h0
`define DMC_HB_INCR 3'h1
`define DMC_MAX_BEATS 5'h10
`define DMC_DESC_WORDS 3'h4
// Buffer size field of the descriptor control word, bits 11..0
`define DMC_BTS_MSB 11
`define DMC_NULL_PTR 32'h0000_0000

`endif

/* verification/dmc_ahb_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// AHB-Lite slave memory, 1 KiB
// ----------------------------------------
module dmc_ahb_mem (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready
);
  logic [31:0] mem [0:255];
  logic [31:0] pa;
  logic [31:0] last;
  logic [2:0] ps;
  logic ph;
  logic pw;
  logic wt;
  // One wait state per data phase when slow
  assign hready = !ph || !slow || wt;
  // Outside a finished read the data lines toggle, so stale data never matches
  assign hrdata = (ph && !pw && hready) ? mem[pa[9:2]] : ~last;
  // Data phase tracking and lane-masked writes
  always @(posedge clock) begin
    last <= hrdata;
    if (!rst_n) begin
      ph <= 1'b0;
      wt <= 1'b0;
    end else begin
      wt <= ph && !hready;
      if (hready) begin
        if (ph && pw) begin
          case (ps)
            3'h0: mem[pa[9:2]][8*pa[1:0]+:8] <= hwdata[8*pa[1:0]+:8];
            3'h1: mem[pa[9:2]][16*pa[1]+:16] <= hwdata[16*pa[1]+:16];
            default: mem[pa[9:2]] <= hwdata;
          endcase
        end
        ph <= htrans[1];
        pw <= hwrite;
        pa <= haddr;
        ps <= hsize;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/dmc_core_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmc_regs.vh"
// ----------------------------------------
// Self-checking bench for the DMA core
// ----------------------------------------
module dmc_core_bench;
  localparam logic [7:0] w_inc = {`DMC_SZ_WORD, `DMC_SZ_WORD, `DMC_AM_INC, `DMC_AM_INC};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic pol = 1'b0, slow = 1'b1;
  logic [3:0] ena = 4'h0, smem = 4'h0, dmem = 4'h0, shw = 4'h0, sch = 4'h0;
  logic [127:0] sa = '0, da = '0, dp = '0;
  logic [47:0] bs = '0;
  logic [7:0] ssz = '0, dsz = '0, smd = '0, dmd = '0, bl = '0, sws = '0;
  logic [15:0] sln = '0, hsreq = '0, hcreq = '0, chunk = 16'hFFFF;
  wire [7:0] swp;
  wire [15:0] ack;
  wire [3:0] act, done;
  wire irq, hwrite, hready, hmastlock;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize, hburst;
  int mismatches = 0, compares = 0, lock_cycles = 0;

  dmc_core dut (.clock(clock), .rst_n(rst_n), .arbitration_policy_select(pol),
    .ch_enable(ena), .ch_src_addr(sa), .ch_dst_addr(da), .ch_desc_ptr(dp), .ch_buf_size(bs),
    .ch_src_size(ssz), .ch_dst_size(dsz), .ch_src_mode(smd), .ch_dst_mode(dmd),
    .ch_src_mem(smem), .ch_dst_mem(dmem), .ch_src_hw(shw), .ch_dst_hw(4'h0),
    .ch_src_line(sln), .ch_dst_line(16'h0000), .ch_src_chain(sch), .ch_dst_chain(4'h0),
    .ch_chunk(chunk), .ch_chan_lock(8'h00), .ch_bus_lock(bl), .hw_single_req(hsreq),
    .hw_chunk_req(hcreq), .sw_single_set(sws), .sw_chunk_set(8'h00), .sw_single_pend(swp),
    .sw_chunk_pend(), .hw_ack(ack), .ch_active(act), .ch_done(done), .dma_irq(irq),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
    .hprot(), .hmastlock(hmastlock), .hwdata(hwdata), .hrdata(hrdata), .hready(hready));
  dmc_ahb_mem mem_i (.clock(clock), .rst_n(rst_n), .slow(slow), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hready(hready));

  // Free-running clock, 20 ns period
  initial begin
    forever #10 clock = ~clock;
  end
  // Cycles with the bus lock up
  always @(posedge clock) begin
    if (hmastlock === 1'b1) lock_cycles++;
  end

  // Distinct bytes per word so lane and order slips show
  function automatic logic [31:0] pat(input logic [7:0] x);
    return {x ^ 8'hF0, x ^ 8'h0F, ~x, x};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("unexpected wait expected event seen none");
    wrap_up();
  endtask
  // Setup; f packs src size, dst size, src mode, dst mode
  task automatic cfg(input int c, input logic [31:0] s, input logic [31:0] d,
                     input logic [11:0] n, input logic [7:0] f, input logic [1:0] m);
    sa[32*c+:32] <= s;
    da[32*c+:32] <= d;
    bs[12*c+:12] <= n;
    {ssz[2*c+:2], dsz[2*c+:2], smd[2*c+:2], dmd[2*c+:2]} <= f;
    {smem[c], dmem[c]} <= m;
  endtask
  // Enable pulse; setup written on the same edge goes with it
  task automatic start(input logic [3:0] m);
    ena <= m;
    @(posedge clock);
    ena <= 4'h0;
    @(negedge clock);
  endtask
  task automatic first_addr(input logic [31:0] exp);
    int k;
    for (k = 0; k < 300 && htrans !== 2'h2; k++) @(negedge clock);
    if (k == 300) timeout();
    check("first address", haddr, exp);
  endtask
  // Completion carries the interrupt and drops the channel
  task automatic wait_done(input int c);
    int k;
    for (k = 0; k < 600 && done[c] !== 1'b1; k++) @(negedge clock);
    if (k == 600) timeout();
    check("irq", irq, 1);
    @(negedge clock);
    check("active", act[c], 0);
  endtask

  // Memory words, wait states, bus locked
  task automatic mem_words();
    int l0;
    int i;
    @(posedge clock);
    cfg(0, 32'h0000_0100, 32'h0000_0200, 12'h003, w_inc, 2'b11);
    bl[1:0] <= `DMC_LK_XFER;
    l0 = lock_cycles;
    start(4'h1);
    wait_done(0);
    for (i = 0; i < 4; i++) begin
      check("dst word", mem_i.mem[8'h80 + i], pat(i < 3 ? 8'h40 + i : 8'h83));
    end
    check("locked", lock_cycles > l0 + 5, 1);
    bl <= 8'h00;
  endtask
  // Falling bytes into words, then a fixed word into falling halves
  task automatic widths();
    logic [31:0] w = pat(8'h40);
    int j;
    @(posedge clock);
    cfg(0, 32'h0000_0103, 32'h0000_0240, 12'h003,
        {`DMC_SZ_BYTE, `DMC_SZ_WORD, `DMC_AM_DEC, `DMC_AM_INC}, 2'b11);
    start(4'h1);
    wait_done(0);
    for (j = 0; j < 3; j++) begin
      check("byte item", mem_i.mem[8'h90 + j], {24'h00_0000, w[8*(3-j)+:8]});
    end
    @(posedge clock);
    cfg(0, 32'h0000_0100, 32'h0000_0282, 12'h002,
        {`DMC_SZ_WORD, `DMC_SZ_HALF, `DMC_AM_FIX, `DMC_AM_DEC}, 2'b11);
    start(4'h1);
    wait_done(0);
    check("half items", mem_i.mem[8'hA0], {w[15:0], w[15:0]});
  endtask
  // Hardware line source: a single, then a one-item chunk
  task automatic hw_src();
    int t;
    int k;
    @(posedge clock);
    cfg(1, 32'h0000_0300, 32'h0000_0220, 12'h002,
        {`DMC_SZ_WORD, `DMC_SZ_WORD, `DMC_AM_FIX, `DMC_AM_INC}, 2'b01);
    shw[1] <= 1'b1;
    sln[7:4] <= `DMC_LINE_SPI_RX;
    chunk[7:4] <= 4'h0;
    start(4'h2);
    repeat (20) @(negedge clock);
    check("waiting", mem_i.mem[8'h88], pat(8'h88));
    for (t = 0; t < 2; t++) begin
      @(posedge clock);
      if (t == 0) hsreq[2] <= 1'b1;
      else hcreq[2] <= 1'b1;
      for (k = 0; k < 300 && !(htrans === 2'h2 && hwrite === 1'b1); k++) @(negedge clock);
      if (k == 300) timeout();
      @(posedge clock);
      hsreq <= 16'h0000;
      hcreq <= 16'h0000;
      for (k = 0; k < 300 && ack === 16'h0000; k++) @(negedge clock);
      if (k == 300) timeout();
      check("ack", ack, 16'h0004);
      check("done", done[1], t);
      check("item", mem_i.mem[8'h88 + t], pat(8'hC0));
      check("next", mem_i.mem[8'h89], t ? pat(8'hC0) : pat(8'h89));
    end
  endtask
  // Software request for a peripheral destination, without wait states
  task automatic sw_dst();
    @(posedge clock);
    slow <= 1'b0;
    cfg(2, 32'h0000_0104, 32'h0000_0230, 12'h001, w_inc, 2'b10);
    start(4'h4);
    repeat (10) @(negedge clock);
    check("no request", mem_i.mem[8'h8C], pat(8'h8C));
    @(posedge clock);
    sws[5] <= 1'b1;
    @(posedge clock);
    sws[5] <= 1'b0;
    @(negedge clock);
    check("pending", swp[5], 1);
    wait_done(2);
    check("cleared", swp[5], 0);
    check("sw item", mem_i.mem[8'h8C], pat(8'h41));
  endtask
  // Fixed priority: channel 3 beats channel 0
  task automatic fixed_prio();
    @(posedge clock);
    pol <= 1'b1;
    slow <= 1'b1;
    cfg(0, 32'h0000_0100, 32'h0000_0250, 12'h002, w_inc, 2'b11);
    cfg(3, 32'h0000_0110, 32'h0000_0260, 12'h002, w_inc, 2'b11);
    start(4'h9);
    first_addr(32'h0000_0110);
    wait_done(3);
    wait_done(0);
    check("ch3 data", mem_i.mem[8'h98], pat(8'h44));
    check("ch0 data", mem_i.mem[8'h94], pat(8'h40));
  endtask
  // Chained source buffers, contiguous destination
  task automatic chained();
    logic [31:0] d [8] = '{32'h0000_0108, 32'h0000_03F0, 32'h0000_0390, 32'h0000_0002,
                           32'h0000_0118, 32'h0000_03F0, 32'h0000_0000, 32'h0000_0001};
    int i;
    for (i = 0; i < 8; i++) mem_i.mem[8'hE0 + i] = d[i];
    @(posedge clock);
    cfg(0, 32'h0000_0000, 32'h0000_02C0, 12'h001, w_inc, 2'b11);
    sch[0] <= 1'b1;
    dp[31:0] <= 32'h0000_0380;
    start(4'h1);
    first_addr(32'h0000_0380);
    wait_done(0);
    check("buf a0", mem_i.mem[8'hB0], pat(8'h42));
    check("buf a1", mem_i.mem[8'hB1], pat(8'h43));
    check("buf b0", mem_i.mem[8'hB2], pat(8'h46));
    check("past end", mem_i.mem[8'hB3], pat(8'hB3));
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) mem_i.mem[i] = pat(i[7:0]);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    mem_words();
    widths();
    hw_src();
    sw_dst();
    fixed_prio();
    chained();
    wrap_up();
  end
endmodule

bind dmc_core dmc_core_properties u_props (.*);
`default_nettype wire

/* verification/dmc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the DMA core
// ----------------------------------------
module dmc_core_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] hw_ack,
  input wire logic [3:0] ch_active,
  input wire logic [3:0] ch_done,
  input wire logic dma_irq,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic hmastlock,
  input wire logic hready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [4:0] beats;
  // Beats of the running burst; five bits so a seventeenth shows
  always @(posedge clock) begin
    if (!rst_n) begin
      beats <= 5'h00;
    end else if (htrans[1] && hready) begin
      beats <= htrans[0] ? beats + 5'h01 : 5'h01;
    end
  end
  sequence s_taken;
    htrans[1] && hready;
  endsequence
  sequence s_next_beat;
    s_taken ##1 htrans == 2'h3;
  endsequence
  AST_HOLD_CTRL: assert property (htrans[1] && !hready |=>
    $stable(haddr) && $stable(htrans) && $stable(hwrite) && $stable(hsize))
    else $error("address phase moved in a wait state");
  AST_BEAT_ADDR: assert property (s_next_beat |->
    hburst == 3'h1 && haddr == $past(haddr) + (32'h1 << hsize) && hwrite == $past(hwrite))
    else $error("burst beat not incrementing");
  AST_BURST_MAX: assert property (beats <= 5'h10)
    else $error("burst longer than sixteen beats");
  AST_SINGLE_ALONE: assert property (hburst == 3'h0 && htrans == 2'h2 && hready
    |=> htrans != 2'h3)
    else $error("single access followed by a burst beat");
  AST_ACK_PULSE: assert property (hw_ack != 16'h0000 |=>
    (hw_ack & $past(hw_ack)) == 16'h0000)
    else $error("ack longer than one cycle");
  AST_IRQ_DONE: assert property (dma_irq == (ch_done != 4'h0))
    else $error("irq does not match completion");
  AST_DONE_OFF: assert property (ch_done != 4'h0 |=>
    (ch_active & $past(ch_done)) == 4'h0)
    else $error("channel active after completion");
  AST_LOCK_ACTIVE: assert property (hmastlock |-> ch_active != 4'h0)
    else $error("bus lock without an active channel");
endmodule
`default_nettype wire
